// File: lmp_core.sv
// Register file, row scan, column PWM and open/short detection of the
// 12-column LED matrix driver core.
// Assumes the serial slave delivers pointer loads, data bytes and reads
// as single-cycle strobes on core_clk; fault senses are asynchronous.
`timescale 1ns/1ps
module lmp_core #(
	parameter int SWEEP_CYC = lmp_pkg::SWEEP_CYC
) (
	input  wire logic        core_clk,             // Core clock, 10 MHz
	input  wire logic        rst_n,                // Sync reset, active low
	input  wire logic        ptr_load,             // Load register pointer
	input  wire logic [6:0]  ptr_addr,             // Pointer value
	input  wire logic        data_wr,              // Write byte at pointer
	input  wire logic [7:0]  data_byte,            // Write data
	input  wire logic [6:0]  rd_addr,              // Read address
	input  wire logic        rd_req,               // Read strobe
	output logic      [7:0]  rd_data,              // Read data, registered
	input  wire logic [11:0] open_sense,           // Open comparators, async
	input  wire logic [11:0] short_sense,          // Short comparators, async
	output logic      [11:0] current_sink_column,  // Column sink enables
	output logic      [2:0]  row_switch,           // Row switch enables
	output logic             row_pulldown_en,      // Row pull-down active
	output logic      [2:0]  row_pulldown_level,   // Row pull-down level
	output logic             column_pullup_en,     // Column pull-up active
	output logic      [2:0]  column_pullup_level,  // Column pull-up level
	output logic      [7:0]  global_current_code,  // Global current code
	output logic      [95:0] channel_scale_code,   // Twelve scale codes
	output logic             low_current_accuracy, // Quarter-current mode
	output logic             detect_busy           // Detection pass running
);
	// ---------------------------------------------------------------
	// Register storage
	// ---------------------------------------------------------------
	logic [7:0]  config_q;
	logic [7:0]  global_q;
	logic [7:0]  scale_q [lmp_pkg::N_COL];
	logic [7:0]  duty_q [2 * lmp_pkg::N_DOT];
	logic [7:0]  pull_q;
	logic [7:0]  detfreq_q;
	logic [7:0]  spread_q;
	logic [6:0]  ptr_q;
	logic [35:0] open_q;
	logic [35:0] short_q;
	logic        soft_reset;
	logic        trig_wr;

	assign soft_reset = data_wr && ptr_q == lmp_pkg::ADDR_RESET
		&& data_byte == lmp_pkg::RESET_KEY;
	assign trig_wr = data_wr && ptr_q == lmp_pkg::ADDR_DETFREQ;

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			ptr_q <= 7'h00;
		else if (ptr_load)
			ptr_q <= ptr_addr;
		else if (data_wr)
			ptr_q <= ptr_q + 7'h01;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n || soft_reset) begin
			config_q <= lmp_pkg::RST_CONFIG;
			global_q <= lmp_pkg::RST_GLOBAL;
			pull_q   <= lmp_pkg::RST_PULL;
			spread_q <= lmp_pkg::RST_SPREAD;
		end else if (data_wr) begin
			unique case (ptr_q)
				lmp_pkg::ADDR_CONFIG: config_q <= data_byte & 8'h7F;
				lmp_pkg::ADDR_GLOBAL: global_q <= data_byte;
				lmp_pkg::ADDR_PULL:   pull_q   <= data_byte;
				lmp_pkg::ADDR_SPREAD: spread_q <= data_byte & 8'h10;
				default: ;
			endcase
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < lmp_pkg::N_COL; gi++) begin : g_scale
			always_ff @(posedge core_clk) begin
				if (!rst_n || soft_reset)
					scale_q[gi] <= 8'h00;
				else if (data_wr && ptr_q == lmp_pkg::ADDR_SCALE_LO + 7'(gi))
					scale_q[gi] <= data_byte;
			end
			assign channel_scale_code[gi*8 +: 8] = scale_q[gi];
		end
		for (gi = 0; gi < 2 * lmp_pkg::N_DOT; gi++) begin : g_duty
			always_ff @(posedge core_clk) begin
				if (!rst_n || soft_reset)
					duty_q[gi] <= 8'h00;
				else if (data_wr && ptr_q == lmp_pkg::ADDR_DUTY_LO + 7'(gi))
					duty_q[gi] <= (gi % 2 == 1) ? (data_byte & 8'h0F) : data_byte;
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// Decoded controls
	// ---------------------------------------------------------------
	logic       running;
	logic       res8;
	logic [1:0] scan_select;
	logic [2:0] frequency_select;
	logic [2:0] nrows;
	logic [15:0] step_nom;

	assign running = config_q[lmp_pkg::CFG_SSD];
	assign res8    = config_q[lmp_pkg::CFG_RES];
	assign scan_select     = config_q[lmp_pkg::CFG_SWS +: 2];
	assign frequency_select     = detfreq_q[lmp_pkg::DF_PFS +: 3];

	// Row count per scan mode
	always_comb begin
		unique case (lmp_pkg::lmp_scan_t'(scan_select))
			lmp_pkg::LMP_SCAN2:  nrows = 3'd2;
			lmp_pkg::LMP_NOSCAN: nrows = 3'd1;
			default:             nrows = 3'd3;
		endcase
	end

	// Low codes only speed up 8-bit mode; upper codes halve from 4 kHz
	always_comb begin
		if (frequency_select[2])
			step_nom = lmp_pkg::STEP12 >> frequency_select[1:0];
		else if (res8)
			step_nom = lmp_pkg::STEP8 >> frequency_select[1:0];
		else
			step_nom = lmp_pkg::STEP12;
	end

	logic [15:0] phase;
	logic        wrap;

	lmp_timebase #(
		.SWEEP_CYC (SWEEP_CYC)
	) u_timebase (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.run       (running),
		.step      (step_nom),
		.spread_en (spread_q[lmp_pkg::SS_EN]),
		.phase     (phase),
		.wrap      (wrap)
	);

	// ---------------------------------------------------------------
	// Row scan and non-overlap
	// ---------------------------------------------------------------
	logic [1:0] row_q;
	logic [3:0] nol_q;
	logic       gap;

	always_ff @(posedge core_clk) begin
		if (!rst_n || !running) begin
			row_q <= 2'd0;
			nol_q <= lmp_pkg::GAP_A_CYC + lmp_pkg::GAP_B_CYC;
		end else if (wrap) begin
			row_q <= (3'(row_q) + 3'd1 >= nrows) ? 2'd0 : row_q + 2'd1;
			nol_q <= lmp_pkg::GAP_A_CYC + lmp_pkg::GAP_B_CYC;
		end else if (nol_q != 4'd0) begin
			nol_q <= nol_q - 4'd1;
		end
	end

	assign gap = running && nol_q != 4'd0;

	// Rows stay dark for gap A, columns wait gap B more
	always_ff @(posedge core_clk) begin
		// A row beyond the scan length stays dark until the next wrap
		if (!rst_n || !running || scan_select == 2'b11 || nol_q > lmp_pkg::GAP_B_CYC
			|| 3'(row_q) >= nrows)
			row_switch <= 3'b000;
		else
			row_switch <= 3'(1) << row_q;
	end

	// ---------------------------------------------------------------
	// Detection sequencing
	// ---------------------------------------------------------------
	logic [11:0] open_s1, open_s2, open_s3, open_f;
	logic [11:0] short_s1, short_s2, short_s3, short_f;
	logic        det_open_q;
	logic        det_short_q;
	logic [2:0]  det_cnt_q;
	logic        last_row_done;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			open_s1 <= 12'h000;
			open_s2 <= 12'h000;
			open_s3 <= 12'h000;
			short_s1 <= 12'h000;
			short_s2 <= 12'h000;
			short_s3 <= 12'h000;
		end else begin
			open_s1 <= open_sense;
			open_s2 <= open_s1;
			open_s3 <= open_s2;
			short_s1 <= short_sense;
			short_s2 <= short_s1;
			short_s3 <= short_s2;
		end
	end

	// Filtered copy moves only when stages two and three agree
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			open_f  <= 12'h000;
			short_f <= 12'h000;
		end else begin
			open_f  <= (open_s2 & open_s3) | (open_f & (open_s2 | open_s3));
			short_f <= (short_s2 & short_s3) | (short_f & (short_s2 | short_s3));
		end
	end

	// First wrap ends a partial row, so a pass spans nrows + 1 wraps
	assign last_row_done = wrap && det_cnt_q >= nrows;

	always_ff @(posedge core_clk) begin
		if (!rst_n || soft_reset) begin
			det_open_q  <= 1'b0;
			det_short_q <= 1'b0;
			detfreq_q   <= lmp_pkg::RST_DETFREQ;
			det_cnt_q   <= 3'd0;
		end else begin
			if (trig_wr) begin
				detfreq_q <= data_byte & 8'hFC;
				// A trigger write wins over a pass finishing this cycle
				det_open_q  <= data_byte[lmp_pkg::DF_OEN] | (det_open_q & !last_row_done);
				det_short_q <= data_byte[lmp_pkg::DF_SEN] | (det_short_q & !last_row_done);
			end else if (last_row_done) begin
				det_open_q  <= 1'b0;
				det_short_q <= 1'b0;
			end
			if (trig_wr && (data_byte[lmp_pkg::DF_OEN] || data_byte[lmp_pkg::DF_SEN]))
				det_cnt_q <= 3'd0;
			else if (detect_busy && wrap)
				det_cnt_q <= last_row_done ? 3'd0 : det_cnt_q + 3'd1;
		end
	end

	assign detect_busy = det_open_q || det_short_q;

	generate
		for (gi = 0; gi < lmp_pkg::N_ROW; gi++) begin : g_fault
			always_ff @(posedge core_clk) begin
				if (!rst_n || soft_reset) begin
					open_q[gi*12 +: 12]  <= 12'h000;
					short_q[gi*12 +: 12] <= 12'h000;
				end else if (wrap && det_cnt_q != 3'd0 && row_q == 2'(gi)) begin
					if (det_open_q)
						open_q[gi*12 +: 12] <= open_f;
					if (det_short_q)
						short_q[gi*12 +: 12] <= short_f;
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// Column PWM
	// ---------------------------------------------------------------
	logic [7:0] min8;

	always_comb begin
		unique case (detfreq_q[lmp_pkg::DF_MDT +: 2])
			2'b00:   min8 = lmp_pkg::MDT_6PCT;
			2'b01:   min8 = lmp_pkg::MDT_3PCT;
			default: min8 = res8 ? lmp_pkg::MDT_12PCT : lmp_pkg::MDT_6PCT;
		endcase
	end

	generate
		for (gi = 0; gi < lmp_pkg::N_COL; gi++) begin : g_col
			logic [5:0]  dot;
			logic [11:0] duty;
			logic [11:0] dmin;
			logic [15:0] ph;
			logic        lit;
			assign dot = 6'(32'(row_q) * lmp_pkg::N_COL + gi);
			// Odd columns run half a period late when phase choice is set
			assign ph = (gi % 2 == 1 && config_q[lmp_pkg::CFG_PHC]) ? phase + 16'h8000 : phase;
			assign dmin = res8 ? {4'h0, min8} : {min8, 4'h0};
			always_comb begin
				if (res8)
					duty = {4'h0, duty_q[2 * dot]};
				else
					duty = {duty_q[2 * dot + 1][3:0], duty_q[2 * dot]};
				if (detect_busy && duty < dmin)
					duty = dmin;
				lit = res8 ? ({4'h0, ph[15:8]} < duty) : (ph[15:4] < duty);
			end
			always_ff @(posedge core_clk) begin
				if (!rst_n || !running || gap)
					current_sink_column[gi] <= 1'b0;
				else
					current_sink_column[gi] <= lit;
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// Pull levels and current codes
	// ---------------------------------------------------------------
	assign row_pulldown_level  = pull_q[lmp_pkg::PUL_ROW_PULLDOWN_LEVEL +: 3];
	assign column_pullup_level = pull_q[lmp_pkg::PUL_COLUMN_PULLUP_LEVEL +: 3];
	assign row_pulldown_en  = running && row_pulldown_level != 3'b000
		&& (pull_q[lmp_pkg::PUL_SWAT] || gap);
	assign column_pullup_en = running && column_pullup_level != 3'b000
		&& (pull_q[lmp_pkg::PUL_CSAT] || gap);
	assign global_current_code  = global_q;
	assign low_current_accuracy = detfreq_q[lmp_pkg::DF_LOW_CURRENT_ACCURACY];

	// ---------------------------------------------------------------
	// Read path
	// ---------------------------------------------------------------
	logic [7:0] rd_mux;
	logic [6:0] fidx;
	logic [5:0] fbase;

	always_comb begin
		fidx   = rd_addr - lmp_pkg::ADDR_OPEN_LO;
		fbase  = 6'(32'(fidx % 7'd6) * 6);
		rd_mux = 8'h00;
		if (rd_addr == lmp_pkg::ADDR_CONFIG)
			rd_mux = config_q;
		else if (rd_addr == lmp_pkg::ADDR_GLOBAL)
			rd_mux = global_q;
		else if (rd_addr >= lmp_pkg::ADDR_SCALE_LO && rd_addr <= lmp_pkg::ADDR_SCALE_HI)
			rd_mux = scale_q[4'(rd_addr - lmp_pkg::ADDR_SCALE_LO)];
		else if (rd_addr == lmp_pkg::ADDR_PULL)
			rd_mux = pull_q;
		else if (rd_addr == lmp_pkg::ADDR_DETFREQ)
			rd_mux = {detfreq_q[7:2], det_short_q, det_open_q};
		else if (rd_addr >= lmp_pkg::ADDR_OPEN_LO && rd_addr < lmp_pkg::ADDR_SHORT_LO)
			rd_mux = {2'b00, open_q[fbase +: 6]};
		else if (rd_addr >= lmp_pkg::ADDR_SHORT_LO && rd_addr <= lmp_pkg::ADDR_FAULT_HI)
			rd_mux = {2'b00, short_q[fbase +: 6]};
		else if (rd_addr == lmp_pkg::ADDR_SPREAD)
			rd_mux = spread_q;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			rd_data <= 8'h00;
		else if (rd_req)
			rd_data <= rd_mux;
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	a_shutdown_dark: assert property (@(posedge core_clk) disable iff (!rst_n)
		!running |=> current_sink_column == 12'h000 && row_switch == 3'b000)
		else $error("outputs active during soft shutdown");
	a_ptr_increment: assert property (@(posedge core_clk) disable iff (!rst_n)
		data_wr && !ptr_load |=> ptr_q == $past(ptr_q) + 7'h01)
		else $error("pointer did not advance after data byte");
	a_two_row_scan: assert property (@(posedge core_clk) disable iff (!rst_n)
		scan_select == 2'b10 |=> !row_switch[2])
		else $error("third row driven in two-row mode");
	a_noscan_rows: assert property (@(posedge core_clk) disable iff (!rst_n)
		scan_select == 2'b11 |=> row_switch == 3'b000)
		else $error("rows switched with scanning off");
	a_gap_columns: assert property (@(posedge core_clk) disable iff (!rst_n)
		running && wrap && !soft_reset |=> ##1 (current_sink_column == 12'h000) [*2])
		else $error("columns lit during non-overlap gap");
	a_pulldown_gap: assert property (@(posedge core_clk) disable iff (!rst_n)
		row_pulldown_en |-> row_pulldown_level != 3'b000
		&& (pull_q[lmp_pkg::PUL_SWAT] || gap))
		else $error("row pull-down outside allowed time");
	a_pullup_gap: assert property (@(posedge core_clk) disable iff (!rst_n)
		column_pullup_en |-> column_pullup_level != 3'b000
		&& (pull_q[lmp_pkg::PUL_CSAT] || gap))
		else $error("column pull-up outside allowed time");
	a_fault_top_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
		rd_req && rd_addr >= lmp_pkg::ADDR_OPEN_LO && rd_addr <= lmp_pkg::ADDR_FAULT_HI
		|=> rd_data[7:6] == 2'b00)
		else $error("fault register top bits not zero");
	a_detect_ends: assert property (@(posedge core_clk) disable iff (!rst_n)
		detect_busy && last_row_done && !trig_wr |=> !detect_busy)
		else $error("detection pass did not end");
	a_reset_pull: assert property (@(posedge core_clk)
		!rst_n |=> pull_q == lmp_pkg::RST_PULL && config_q == lmp_pkg::RST_CONFIG)
		else $error("reset values wrong");
endmodule

// File: lmp_host_model.sv
// Host side of the register port: pointer loads, data bytes, reads.
// Assumes the core samples strobes on the rising edge of core_clk.
`timescale 1ns/1ps
module lmp_host_model (
	input  wire logic       core_clk,  // Core clock
	input  wire logic [7:0] rd_data,   // Registered read data
	output logic            ptr_load,  // Pointer load strobe
	output logic      [6:0] ptr_addr,  // Pointer value
	output logic            data_wr,   // Data byte strobe
	output logic      [7:0] data_byte, // Data byte
	output logic      [6:0] rd_addr,   // Read address
	output logic            rd_req     // Read strobe
);
	initial begin
		{ptr_load, data_wr, rd_req} = 3'h0;
		{ptr_addr, rd_addr, data_byte} = 22'h0;
	end
	// Released buses show inverted values so stale data never looks valid
	task automatic burst(input logic [6:0] a, input logic [7:0] d0, d1, input int n);
		@(posedge core_clk) #1;
		ptr_load = 1'b1;
		ptr_addr = a;
		@(posedge core_clk) #1;
		ptr_load = 1'b0;
		ptr_addr = ~a;
		data_wr = 1'b1;
		data_byte = d0;
		@(posedge core_clk) #1;
		if (n > 1) begin
			data_byte = d1;
			@(posedge core_clk) #1;
		end
		data_wr = 1'b0;
		data_byte = ~data_byte;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		burst(a, d, 8'h00, 1);
	endtask
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(posedge core_clk) #1;
		rd_req = 1'b1;
		rd_addr = a;
		@(posedge core_clk) #1;
		rd_req = 1'b0;
		rd_addr = ~a;
		d = rd_data;
	endtask
	// Detection needs a known current, no pulls and a visible duty
	task automatic prep_detect();
		wr(7'h01, 8'h0F);
		wr(7'h60, 8'h00);
		wr(7'h0E, 8'h80);
	endtask
endmodule

// File: lmp_pkg.sv
// Constants shared by the LED matrix PWM core and its timebase.
// Assumes a single 10 MHz core clock; all counts derive from it.
package lmp_pkg;
	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [6:0] ADDR_CONFIG     = 7'h00;
	localparam logic [6:0] ADDR_GLOBAL     = 7'h01;
	localparam logic [6:0] ADDR_SCALE_LO   = 7'h02;
	localparam logic [6:0] ADDR_SCALE_HI   = 7'h0D;
	localparam logic [6:0] ADDR_DUTY_LO    = 7'h0E;
	localparam logic [6:0] ADDR_DUTY_HI    = 7'h55;
	localparam logic [6:0] ADDR_PULL       = 7'h60;
	localparam logic [6:0] ADDR_DETFREQ    = 7'h61;
	localparam logic [6:0] ADDR_OPEN_LO    = 7'h62;
	localparam logic [6:0] ADDR_SHORT_LO   = 7'h68;
	localparam logic [6:0] ADDR_FAULT_HI   = 7'h6D;
	localparam logic [6:0] ADDR_SPREAD     = 7'h6E;
	localparam logic [6:0] ADDR_RESET      = 7'h7F;
	localparam logic [7:0] RESET_KEY       = 8'hAE;
	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] RST_CONFIG      = 8'h02;
	localparam logic [7:0] RST_GLOBAL      = 8'h00;
	localparam logic [7:0] RST_PULL        = 8'h34;
	localparam logic [7:0] RST_DETFREQ     = 8'h00;
	localparam logic [7:0] RST_SPREAD      = 8'h00;
	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int CFG_SSD  = 0;
	localparam int CFG_PHC  = 1;
	localparam int CFG_SWS  = 4;
	localparam int CFG_RES  = 6;
	localparam int PUL_COLUMN_PULLUP_LEVEL = 0;
	localparam int PUL_CSAT = 3;
	localparam int PUL_ROW_PULLDOWN_LEVEL = 4;
	localparam int PUL_SWAT = 7;
	localparam int DF_OEN   = 0;
	localparam int DF_SEN   = 1;
	localparam int DF_MDT   = 2;
	localparam int DF_PFS   = 4;
	localparam int DF_LOW_CURRENT_ACCURACY  = 7;
	localparam int SS_EN    = 4;
	// ---------------------------------------------------------------
	// Geometry and minimum detect duty (8-bit units)
	// ---------------------------------------------------------------
	localparam int N_COL    = 12;
	localparam int N_ROW    = 3;
	localparam int N_DOT    = 36;
	localparam logic [7:0] MDT_6PCT  = 8'h0F;
	localparam logic [7:0] MDT_3PCT  = 8'h08;
	localparam logic [7:0] MDT_12PCT = 8'h1F;
	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_NS          = 100;
	localparam int SCAN12_NS       = 235000;
	localparam int SCAN8_NS        = 15400;
	localparam int GAP_A_NS        = 290;
	localparam int GAP_B_NS        = 120;
	localparam int SWEEP_NS        = 2099000;
	localparam int SPREAD_PERMILLE = 56;
	localparam logic [3:0] GAP_A_CYC = 4'((GAP_A_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] GAP_B_CYC = 4'((GAP_B_NS + CLK_NS - 1) / CLK_NS);
	localparam int SWEEP_CYC       = SWEEP_NS / CLK_NS;
	// Phase step per clock: 2^16 phase units per scan period
	localparam logic [15:0] STEP12   = 16'(65536 * CLK_NS / SCAN12_NS);
	localparam logic [15:0] STEP8    = 16'(65536 * CLK_NS / SCAN8_NS);
	// Scan select modes
	typedef enum logic [1:0] {
		LMP_SCAN3 = 2'h0,
		LMP_SCAN3B = 2'h1,
		LMP_SCAN2 = 2'h2,
		LMP_NOSCAN = 2'h3
	} lmp_scan_t;
endpackage

// File: lmp_timebase.sv
// PWM phase generator with optional triangular spread-spectrum dither.
// Assumes the step input is held stable by the register core.
`timescale 1ns/1ps
module lmp_timebase #(
	parameter int SWEEP_CYC = lmp_pkg::SWEEP_CYC
) (
	input  wire logic        core_clk,   // Core clock
	input  wire logic        rst_n,      // Sync reset, active low
	input  wire logic        run,        // Phase advances while high
	input  wire logic [15:0] step,       // Nominal phase step per clock
	input  wire logic        spread_en,  // Dither enable
	output logic      [15:0] phase,      // Current phase
	output logic             wrap        // One-cycle pulse at period end
);
	// ---------------------------------------------------------------
	// Triangle sweep: 512 slots per sweep cycle
	// ---------------------------------------------------------------
	localparam int SLOT_CYC = (SWEEP_CYC / 512 > 0) ? SWEEP_CYC / 512 : 1;

	logic [15:0] slot_q;
	logic [7:0]  tri_q;
	logic        dir_up_q;
	logic [15:0] phase_q;
	logic [16:0] sum_d;
	logic [23:0] amp;
	logic [23:0] off;
	logic [15:0] step_eff;

	always_ff @(posedge core_clk) begin
		if (!rst_n || !spread_en) begin
			slot_q   <= 16'h0000;
			tri_q    <= 8'h80;
			dir_up_q <= 1'b1;
		end else if (slot_q >= 16'(SLOT_CYC - 1)) begin
			slot_q <= 16'h0000;
			tri_q  <= dir_up_q ? tri_q + 8'h01 : tri_q - 8'h01;
			if (dir_up_q && tri_q == 8'hFE)
				dir_up_q <= 1'b0;
			else if (!dir_up_q && tri_q == 8'h01)
				dir_up_q <= 1'b1;
		end else begin
			slot_q <= slot_q + 16'h0001;
		end
	end

	// Amplitude is the spread fraction of the step; offset spans 0..2*amp, so step + off - amp spans -amp..+amp
	always_comb begin
		amp = 24'((32'(step) * lmp_pkg::SPREAD_PERMILLE) / 1000);
		off = 24'((amp * 24'(tri_q)) >> 7);
		step_eff = spread_en ? 16'(24'(step) + off - amp) : step;
		sum_d = 17'(phase_q) + 17'(step_eff);
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n || !run)
			phase_q <= 16'h0000;
		else
			phase_q <= sum_d[15:0];
	end

	assign phase = phase_q;
	assign wrap  = run && sum_d[16];
endmodule

// File: tb.sv
// Self-checking bench of the matrix core driven through the host model.
// Assumes a 10 MHz clock and eight-bit mode for short scan periods.
`timescale 1ns/1ps
module tb;
	logic        core_clk, rst_n, ptr_load, data_wr, rd_req, row_pulldown_en;
	logic        column_pullup_en, low_current_accuracy, detect_busy;
	logic [6:0]  ptr_addr, rd_addr;
	logic [7:0]  data_byte, rd_data, global_current_code, d;
	logic [11:0] open_sense, short_sense, current_sink_column;
	logic [2:0]  row_switch, row_pulldown_level, column_pullup_level;
	logic [95:0] channel_scale_code;
	int          n_errors = 0, cmp_count = 0, cyc = 0, k;
	logic [22:0] rows [8] = '{{7'h01, 8'hFF, 8'hFF}, {7'h02, 8'h80, 8'h80},
		{7'h0D, 8'h01, 8'h01}, {7'h60, 8'h00, 8'h00}, {7'h6E, 8'h10, 8'h10},
		{7'h0E, 8'h5A, 8'h00}, {7'h62, 8'h3F, 8'h00}, {7'h61, 8'h80, 8'h80}};
	lmp_host_model host_u (.core_clk(core_clk), .rd_data(rd_data), .ptr_load(ptr_load),
		.ptr_addr(ptr_addr), .data_wr(data_wr), .data_byte(data_byte),
		.rd_addr(rd_addr), .rd_req(rd_req));
	lmp_core #(.SWEEP_CYC(512)) dut_u (.core_clk(core_clk), .rst_n(rst_n),
		.ptr_load(ptr_load), .ptr_addr(ptr_addr), .data_wr(data_wr),
		.data_byte(data_byte), .rd_addr(rd_addr), .rd_req(rd_req), .rd_data(rd_data),
		.open_sense(open_sense), .short_sense(short_sense),
		.current_sink_column(current_sink_column), .row_switch(row_switch),
		.row_pulldown_en(row_pulldown_en), .row_pulldown_level(row_pulldown_level),
		.column_pullup_en(column_pullup_en), .column_pullup_level(column_pullup_level),
		.global_current_code(global_current_code), .channel_scale_code(channel_scale_code),
		.low_current_accuracy(low_current_accuracy), .detect_busy(detect_busy));
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			$display("BAD %0t run too long", $time);
			close_out();
		end
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t saw %h wanted %h", $time, seen, exp);
		end
	endtask
	task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
		host_u.rd(a, d);
		chk(16'(d), 16'(exp));
	endtask
	task automatic watch(input logic [2:0] bad, input int n);
		repeat (n) begin
			@(posedge core_clk) #1;
			chk(16'(row_switch & bad), 16'h0000);
		end
	endtask
	task automatic span(input logic [2:0] r, output int n);
		n = 0;
		while (row_switch !== r && n < 2000) begin
			@(posedge core_clk) #1;
			n++;
		end
	endtask
	initial begin
		rst_n = 1'b0;
		open_sense = 12'h000;
		short_sense = 12'h000;
		repeat (3) @(posedge core_clk);
		#1 rst_n = 1'b1;
		rdchk(7'h00, 8'h02);
		rdchk(7'h60, 8'h34);
		chk(16'(row_pulldown_level), 16'h0003);
		chk(16'(column_pullup_level), 16'h0004);
		chk(16'(row_switch), 16'h0000);
		chk(16'(current_sink_column), 16'h0000);
		$display("reset test done");
		// Rows: 01h 02h/0Dh 60h 6Eh 0Eh 62h 61h
		for (int i = 0; i < 8; i++) begin
			host_u.wr(rows[i][22:16], rows[i][15:8]);
			rdchk(rows[i][22:16], rows[i][7:0]);
		end
		chk(16'(global_current_code), 16'h00FF);
		chk(16'(channel_scale_code[7:0]), 16'h0080);
		chk(16'(channel_scale_code[95:88]), 16'h0001);
		chk(16'(low_current_accuracy), 16'h0001);
		host_u.burst(7'h03, 8'hA1, 8'hA2, 2);
		rdchk(7'h03, 8'hA1);
		rdchk(7'h04, 8'hA2);
		$display("register test done");
		host_u.wr(7'h0E, 8'hFF);
		host_u.wr(7'h00, 8'h41);
		span(3'h4, k);
		chk(16'(row_switch), 16'h0004);
		span(3'h1, k);
		chk(16'(k >= 140 && k <= 170), 16'h0001);
		host_u.wr(7'h61, 8'h10);
		span(3'h2, k);
		span(3'h4, k);
		chk(16'(k >= 280 && k <= 340), 16'h0001);
		host_u.wr(7'h60, 8'hBC);
		chk(16'(row_pulldown_en), 16'h0001);
		chk(16'(column_pullup_en), 16'h0001);
		host_u.wr(7'h60, 8'h34);
		span(3'h1, k);
		chk(16'(row_pulldown_en), 16'h0001);
		chk(16'(column_pullup_en), 16'h0001);
		repeat (2) @(posedge core_clk) #1;
		chk(16'(row_pulldown_en), 16'h0000);
		chk(16'(column_pullup_en), 16'h0000);
		host_u.wr(7'h00, 8'h61);
		watch(3'h4, 500);
		host_u.wr(7'h00, 8'h71);
		watch(3'h7, 300);
		host_u.wr(7'h00, 8'h40);
		repeat (2) @(posedge core_clk) #1;
		chk(16'(row_switch), 16'h0000);
		chk(16'(current_sink_column), 16'h0000);
		$display("scan test done");
		host_u.wr(7'h00, 8'h41);
		host_u.prep_detect();
		open_sense = 12'h001;
		short_sense = 12'h040;
		host_u.wr(7'h61, 8'h03);
		chk(16'(detect_busy), 16'h0001);
		k = 0;
		while (detect_busy !== 1'b0 && k < 3000) begin
			@(posedge core_clk) #1;
			k++;
		end
		chk(16'(detect_busy), 16'h0000);
		rdchk(7'h62, 8'h01);
		rdchk(7'h69, 8'h01);
		rdchk(7'h68, 8'h00);
		host_u.wr(7'h7F, 8'hAE);
		rdchk(7'h01, 8'h00);
		$display("detect test done");
		close_out();
	end
endmodule
